// ==== src/cbrmw_regs.svh ====
// address map, reset values and timing counts of the bus access unit
//
// Overview of operation
// - states counted per clock edge; cycles 2/3
// - on-chip memory: two states, 16-bit path
// - peripherals: two or three states, fixed width
// - 16-bit peripheral registers take word access only
// - word to 8-bit peripheral splits in two
// - two-state peripheral timing equals memory timing
// - four states: reset, execute, halt, exception
// - execute holds active high/medium and subactive
// - halt holds sleep, standby, watch, subsleep
// - unmapped writes dropped, reads undefined
// - block move copies count bytes src to dst
// - bit ops read byte, change bit, write back
// - shared timer address: read count, write load
// - port read: pins for inputs, latch for outputs
// - immediate operand needs no memory access
// - 8-bit absolute: upper sixteen bits forced one
// - 16-bit absolute: sign extended to 24 bits
// - relative branch: sign-extended disp plus pc
// - memory indirect: zero-extended, word fetched target
`ifndef CBRMW_REGS_SVH
`define CBRMW_REGS_SVH
`define CBRMW_ROM_LAST    24'h00_7FFF
`define CBRMW_RAM_FIRST   24'hFF_F000
`define CBRMW_RAM_LAST    24'hFF_FF7F
`define CBRMW_P16_FIRST   24'hFF_FF80
`define CBRMW_P16_LAST    24'hFF_FF9F
`define CBRMW_TMR_ADDR    24'hFF_FFB0
`define CBRMW_PDR_ADDR    24'hFF_FFD8
`define CBRMW_PCR_ADDR    24'hFF_FFE8
`define CBRMW_ABS8_UPPER  16'hFFFF
`define CBRMW_IND_UPPER   16'h0000
`define CBRMW_UNDEF_READ  16'hFFFF
`define CBRMW_WO_READ     8'hFF
`define CBRMW_PDR_RESET   8'h00
`define CBRMW_PCR_RESET   8'h00
`define CBRMW_TMR_RESET   8'h00
`define CBRMW_FAST_STATES 2'h2
`define CBRMW_SLOW_STATES 2'h3
`endif

// ==== src/cbrmw_pkg.sv ====
// types shared by the bus access unit
package cbrmw_pkg;
  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_BIT, OP_MOVE,
                            OP_BRANCH} cbrmw_op_t;
  typedef enum logic [2:0] {M_ABS8, M_ABS16, M_ABS24, M_IMM, M_PCREL8,
                            M_PCREL16, M_MEMIND} cbrmw_mode_t;
  typedef enum logic [2:0] {B_SET, B_CLR, B_NOT, B_ST, B_IST} cbrmw_bitop_t;
  typedef enum logic [1:0] {CS_RESET, CS_EXEC, CS_HALT,
                            CS_EXCEPT} cbrmw_cpu_t;
  typedef enum logic [2:0] {SM_ACT_HIGH, SM_ACT_MED, SM_SUBACT,
                            SM_SLEEP_HIGH, SM_SLEEP_MED, SM_STANDBY,
                            SM_WATCH, SM_SUBSLEEP} cbrmw_sub_t;
  typedef enum logic [1:0] {E_IDLE, E_BUS, E_DONE} cbrmw_eng_t;
  typedef enum logic [2:0] {J_RD, J_WR, J_RMW, J_MOVE, J_IND} cbrmw_job_t;
  typedef enum logic [2:0] {R_MEM, R_P16, R_P8, R_INT, R_NONE} cbrmw_reg_t;
endpackage

// ==== src/cbrmw_ea_if.sv ====
// effective address request and answer between engine and calculator
`timescale 1ns/1ns
interface cbrmw_ea_if;
  import cbrmw_pkg::*;
  cbrmw_mode_t mode;
  logic [23:0] field;
  logic [23:0] pc;
  logic [23:0] ea;
  logic        isImm;
  modport calc (input mode, input field, input pc, output ea, output isImm);
  modport user (output mode, output field, output pc, input ea, input isImm);
endinterface

// ==== src/cbrmw_ea_calc.sv ====
// effective address calculation for absolute, immediate, relative, indirect
`timescale 1ns/1ns
`include "cbrmw_regs.svh"
module cbrmw_ea_calc
  import cbrmw_pkg::*;
(
  cbrmw_ea_if.calc eaIf  // address request and answer
);
  ///////////////////////////////////////////////////////////////////////////
  // address forming per mode
  always_comb begin
    eaIf.isImm = 1'b0;
    case (eaIf.mode)
      M_ABS8:    eaIf.ea = {`CBRMW_ABS8_UPPER, eaIf.field[7:0]};
      M_ABS16:   eaIf.ea = {{8{eaIf.field[15]}}, eaIf.field[15:0]};
      M_ABS24:   eaIf.ea = eaIf.field;
      M_IMM: begin
        eaIf.ea    = eaIf.field;
        eaIf.isImm = 1'b1;
      end
      M_PCREL8:  eaIf.ea = eaIf.pc + {{16{eaIf.field[7]}}, eaIf.field[7:0]};
      M_PCREL16: eaIf.ea = eaIf.pc + {{8{eaIf.field[15]}},
                                      eaIf.field[15:0]};
      M_MEMIND:  eaIf.ea = {`CBRMW_IND_UPPER, eaIf.field[7:0]};
      default:   eaIf.ea = eaIf.field;
    endcase
  end
endmodule

// ==== src/cbrmw_access_unit.sv ====
// processor memory access engine with bit read-modify-write and cpu states
`timescale 1ns/1ns
`include "cbrmw_regs.svh"
module cbrmw_access_unit
  import cbrmw_pkg::*;
(
  input  wire logic         clock,        // 50 MHz system clock
  input  wire logic         rst_n,        // asynchronous reset
  input  wire logic         cmdValid,     // command offered
  input  wire cbrmw_op_t    cmdOp,        // command kind
  input  wire cbrmw_mode_t  cmdMode,      // addressing mode
  input  wire logic [23:0]  cmdField,     // address, disp or immediate
  input  wire logic [23:0]  cmdPc,        // pc of next instruction
  input  wire logic         cmdWord,      // word size when high
  input  wire logic [15:0]  cmdWdata,     // write data
  input  wire cbrmw_bitop_t cmdBitOp,     // bit operation
  input  wire logic [2:0]   cmdBitNum,    // bit number
  input  wire logic         cmdBitIn,     // bit value for stores
  input  wire logic [23:0]  cmdSrc,       // move source pointer
  input  wire logic [23:0]  cmdDst,       // move destination pointer
  input  wire logic [15:0]  cmdCount,     // move count
  input  wire logic         cmdCountWide, // use 16-bit count
  input  wire logic         haltReq,      // enter program halt
  input  wire cbrmw_sub_t   haltMode,     // halt sub-mode
  input  wire logic         wakeReq,      // leave program halt
  input  wire cbrmw_sub_t   runMode,      // execution sub-mode
  input  wire logic         excReq,       // exception request
  input  wire logic         excDone,      // exception handling over
  input  wire logic [15:0]  busRdata,     // far-side read data
  input  wire logic [7:0]   portPinIn,    // port pin levels
  output logic              cmdReady,     // command may be offered
  output logic              doneValid,    // result pulse
  output logic [15:0]       doneData,     // result data
  output logic [23:0]       doneAddr,     // address or branch target
  output logic [23:0]       busAddr,      // cycle address
  output logic [15:0]       busWdata,     // cycle write data
  output logic              busRead,      // far-side read level
  output logic              busWrite,     // far-side write level
  output logic              busByte,      // byte-sized cycle
  output logic              busStart,     // first state of a cycle
  output logic [7:0]        portOut,      // port data latch
  output logic [7:0]        portDir,      // port direction, 1 output
  output cbrmw_cpu_t        cpuState,     // top-level cpu state
  output cbrmw_sub_t        cpuMode       // cpu sub-mode
);
  ///////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops
  logic [1:0] rstSync_q;
  logic       rstInt_n;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) rstSync_q <= 2'h0;
    else        rstSync_q <= {rstSync_q[0], 1'b1};
  end
  assign rstInt_n = rstSync_q[1];

  ///////////////////////////////////////////////////////////////////////////
  // address region decode
  function automatic cbrmw_reg_t region(input logic [23:0] a);
    if (a == `CBRMW_TMR_ADDR || a == `CBRMW_PDR_ADDR ||
        a == `CBRMW_PCR_ADDR)                            return R_INT;
    if (a <= `CBRMW_ROM_LAST)                            return R_MEM;
    if (a >= `CBRMW_RAM_FIRST && a <= `CBRMW_RAM_LAST)   return R_MEM;
    if (a >= `CBRMW_P16_FIRST && a <= `CBRMW_P16_LAST)   return R_P16;
    if (a > `CBRMW_P16_LAST)                             return R_P8;
    return R_NONE;
  endfunction

  cbrmw_ea_if eaIf ();
  cbrmw_ea_calc uEa (.eaIf(eaIf));
  assign eaIf.mode  = cmdMode;
  assign eaIf.field = cmdField;
  assign eaIf.pc    = cmdPc;

  cbrmw_eng_t  eng_q, eng_d;
  cbrmw_job_t  job_q, job_d;
  cbrmw_bitop_t bop_q, bop_d;
  logic        lo_q, lo_d, wr_q, wr_d, bitIn_q, bitIn_d, spl_q, spl_d;
  logic [1:0]  stCnt_q, stCnt_d, len_q, len_d;
  logic [2:0]  bitNum_q, bitNum_d;
  logic [15:0] hold_q, hold_d, cnt_q, cnt_d;
  logic [23:0] src_q, src_d, dst_q, dst_d;
  logic        rdy_q, rdy_d, dv_q, dv_d, rd_q, rd_d, we_q, we_d;
  logic        byte_q, byte_d, st_q, st_d;
  logic [15:0] dd_q, dd_d, wd_q, wd_d;
  logic [23:0] da_q, da_d, ba_q, ba_d;
  logic [7:0]  pdr_q, pdr_d, pcr_q, pcr_d, tld_q, tld_d, tcn_q, tcn_d;
  cbrmw_cpu_t  cs_q, cs_d;
  cbrmw_sub_t  sm_q, sm_d;

  cbrmw_reg_t  curReg, newReg;
  logic        finish, go, goWr, goByte, split, intWr;
  logic [23:0] goAddr;
  logic [15:0] goData, rdWord;
  logic [7:0]  intByte, rdByte, newByte, bitMask;

  ///////////////////////////////////////////////////////////////////////////
  // read answer: inner registers, undefined for unmapped, else far side
  always_comb begin
    curReg = region(ba_q);
    case (ba_q)
      `CBRMW_TMR_ADDR: intByte = tcn_q;
      `CBRMW_PDR_ADDR: intByte = (pcr_q & pdr_q) | (~pcr_q & portPinIn);
      default:         intByte = `CBRMW_WO_READ;
    endcase
    if (curReg == R_INT)       rdWord = {intByte, intByte};
    else if (curReg == R_NONE) rdWord = `CBRMW_UNDEF_READ;
    else                       rdWord = busRdata;
    rdByte  = ba_q[0] ? rdWord[7:0] : rdWord[15:8];
    bitMask = 8'h01 << bitNum_q;
    case (bop_q)
      B_SET:   newByte = rdByte | bitMask;
      B_CLR:   newByte = rdByte & ~bitMask;
      B_NOT:   newByte = rdByte ^ bitMask;
      B_ST:    newByte = bitIn_q ? (rdByte | bitMask) : (rdByte & ~bitMask);
      B_IST:   newByte = bitIn_q ? (rdByte & ~bitMask) : (rdByte | bitMask);
      default: newByte = rdByte;
    endcase
  end

  assign finish = (eng_q == E_BUS) && (stCnt_q == len_q - 2'h1);
  assign intWr  = finish && wr_q && (curReg == R_INT);

  ///////////////////////////////////////////////////////////////////////////
  // access engine next state
  always_comb begin
    eng_d = eng_q; job_d = job_q; bop_d = bop_q; lo_d = lo_q; wr_d = wr_q;
    bitIn_d = bitIn_q; stCnt_d = stCnt_q; len_d = len_q; bitNum_d = bitNum_q;
    hold_d = hold_q; cnt_d = cnt_q; src_d = src_q; dst_d = dst_q;
    spl_d = spl_q;
    dv_d = 1'b0; dd_d = dd_q; da_d = da_q; st_d = 1'b0;
    go = 1'b0; goWr = 1'b0; goByte = 1'b1; goAddr = ba_q; goData = wd_q;
    split = cmdWord && (region(eaIf.ea) == R_P8);
    case (eng_q)
      E_IDLE: begin
        if (cmdValid && rdy_q) begin
          bop_d = cmdBitOp; bitNum_d = cmdBitNum; bitIn_d = cmdBitIn;
          lo_d = 1'b0; hold_d = cmdWdata; da_d = eaIf.ea;
          spl_d = split;
          case (cmdOp)
            OP_READ, OP_WRITE: begin
              if (eaIf.isImm) begin
                dd_d = cmdField[15:0];
                eng_d = E_DONE;
              end else begin
                job_d = (cmdOp == OP_WRITE) ? J_WR : J_RD;
                go = 1'b1; goWr = (cmdOp == OP_WRITE);
                goByte = !cmdWord || split;
                goAddr = split ? {eaIf.ea[23:1], 1'b0} : eaIf.ea;
                goData = (split || !cmdWord) ?
                         {2{(split ? cmdWdata[15:8] : cmdWdata[7:0])}} :
                         cmdWdata;
              end
            end
            OP_BIT: begin
              job_d = J_RMW; go = 1'b1; goAddr = eaIf.ea;
            end
            OP_MOVE: begin
              job_d = J_MOVE; src_d = cmdSrc; dst_d = cmdDst;
              cnt_d = cmdCountWide ? cmdCount : {8'h00, cmdCount[7:0]};
              if (cnt_d == 16'h0000) eng_d = E_DONE;
              else begin
                go = 1'b1; goAddr = cmdSrc;
              end
            end
            OP_BRANCH: begin
              if (cmdMode == M_MEMIND) begin
                job_d = J_IND; go = 1'b1; goByte = 1'b0; goAddr = eaIf.ea;
              end else eng_d = E_DONE;
            end
            default: eng_d = E_DONE;
          endcase
        end
      end
      E_BUS: begin
        stCnt_d = stCnt_q + 2'h1;
        if (finish) begin
          eng_d = E_DONE;
          case (job_q)
            J_RD: begin
              dd_d = byte_q ? {8'h00, rdByte} : rdWord;
              if (spl_q && !lo_q) begin
                dd_d = {rdByte, 8'h00};
                lo_d = 1'b1; go = 1'b1; goAddr = {ba_q[23:1], 1'b1};
              end else if (lo_q) dd_d = {dd_q[15:8], rdByte};
            end
            J_WR: begin
              if (spl_q && !lo_q) begin
                lo_d = 1'b1; go = 1'b1; goWr = 1'b1;
                goAddr = {ba_q[23:1], 1'b1}; goData = {2{hold_q[7:0]}};
              end
            end
            J_RMW: begin
              if (!lo_q) begin
                lo_d = 1'b1; go = 1'b1; goWr = 1'b1;
                goData = {2{newByte}}; dd_d = {8'h00, newByte};
              end
            end
            J_MOVE: begin
              if (!lo_q) begin
                lo_d = 1'b1; go = 1'b1; goWr = 1'b1; goAddr = dst_q;
                goData = {2{rdByte}};
              end else begin
                src_d = src_q + 24'h00_0001; dst_d = dst_q + 24'h00_0001;
                cnt_d = cnt_q - 16'h0001; lo_d = 1'b0; da_d = dst_d;
                if (cnt_d != 16'h0000) begin
                  go = 1'b1; goAddr = src_d;
                end
              end
            end
            J_IND: da_d = {8'h00, rdWord};
            default: ;
          endcase
          if (go) eng_d = E_BUS;
        end
      end
      E_DONE: begin
        dv_d = 1'b1; eng_d = E_IDLE;
      end
      default: eng_d = E_IDLE;
    endcase
    // every cycle starts at state one; three states only for 8-bit
    if (go) begin
      newReg = region(goAddr);
      eng_d = E_BUS; stCnt_d = 2'h0; st_d = 1'b1; wr_d = goWr;
      len_d = (newReg == R_P8 || newReg == R_INT) ?
              `CBRMW_SLOW_STATES : `CBRMW_FAST_STATES;
      ba_d = goAddr; byte_d = goByte; wd_d = goData;
      if (newReg == R_P16 && goByte) newReg = R_NONE;
      rd_d = !goWr && (newReg != R_NONE) && (newReg != R_INT);
      we_d = goWr && (newReg != R_NONE) && (newReg != R_INT);
    end else begin
      newReg = R_NONE; ba_d = ba_q; byte_d = byte_q; wd_d = wd_q;
      rd_d = rd_q && !finish; we_d = we_q && !finish;
    end
    rdy_d = (eng_d == E_IDLE) && (cs_q == CS_EXEC);
  end

  ///////////////////////////////////////////////////////////////////////////
  // inner registers and cpu state next values
  always_comb begin
    pdr_d = pdr_q; pcr_d = pcr_q; tld_d = tld_q;
    tcn_d = (tcn_q == 8'h00) ? tld_q : tcn_q - 8'h01;
    if (intWr) begin
      case (ba_q)
        `CBRMW_TMR_ADDR: tld_d = wd_q[7:0];
        `CBRMW_PDR_ADDR: pdr_d = wd_q[7:0];
        default:         pcr_d = wd_q[7:0];
      endcase
    end
    cs_d = cs_q; sm_d = sm_q;
    case (cs_q)
      CS_RESET: cs_d = CS_EXCEPT;
      CS_EXEC: begin
        sm_d = (runMode <= SM_SUBACT) ? runMode : SM_ACT_HIGH;
        if (excReq) cs_d = CS_EXCEPT;
        else if (haltReq && eng_q == E_IDLE && !cmdValid) begin
          cs_d = CS_HALT;
          sm_d = (haltMode >= SM_SLEEP_HIGH) ? haltMode : SM_SLEEP_HIGH;
        end
      end
      CS_HALT:   if (wakeReq || excReq) cs_d = CS_EXCEPT;
      CS_EXCEPT: if (excDone) cs_d = CS_EXEC;
      default:   cs_d = CS_RESET;
    endcase
  end

  ///////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock or negedge rstInt_n) begin
    if (!rstInt_n) begin
      eng_q <= E_IDLE; job_q <= J_RD; bop_q <= B_SET; lo_q <= 1'b0;
      wr_q <= 1'b0; bitIn_q <= 1'b0; stCnt_q <= 2'h0; len_q <= 2'h2;
      bitNum_q <= 3'h0; hold_q <= 16'h0000; cnt_q <= 16'h0000;
      src_q <= 24'h00_0000; dst_q <= 24'h00_0000; rdy_q <= 1'b0;
      spl_q <= 1'b0;
      dv_q <= 1'b0; rd_q <= 1'b0; we_q <= 1'b0; byte_q <= 1'b0;
      st_q <= 1'b0; dd_q <= 16'h0000; wd_q <= 16'h0000;
      da_q <= 24'h00_0000; ba_q <= 24'h00_0000;
      pdr_q <= `CBRMW_PDR_RESET; pcr_q <= `CBRMW_PCR_RESET;
      tld_q <= `CBRMW_TMR_RESET; tcn_q <= `CBRMW_TMR_RESET;
      cs_q <= CS_RESET; sm_q <= SM_ACT_HIGH;
    end else begin
      eng_q <= eng_d; job_q <= job_d; bop_q <= bop_d; lo_q <= lo_d;
      wr_q <= wr_d; bitIn_q <= bitIn_d; stCnt_q <= stCnt_d; len_q <= len_d;
      bitNum_q <= bitNum_d; hold_q <= hold_d; cnt_q <= cnt_d;
      src_q <= src_d; dst_q <= dst_d; rdy_q <= rdy_d;
      spl_q <= spl_d;
      dv_q <= dv_d; rd_q <= rd_d; we_q <= we_d; byte_q <= byte_d;
      st_q <= st_d; dd_q <= dd_d; wd_q <= wd_d; da_q <= da_d; ba_q <= ba_d;
      pdr_q <= pdr_d; pcr_q <= pcr_d; tld_q <= tld_d; tcn_q <= tcn_d;
      cs_q <= cs_d; sm_q <= sm_d;
    end
  end

  assign cmdReady = rdy_q;  assign doneValid = dv_q;  assign doneData = dd_q;
  assign doneAddr = da_q;   assign busAddr = ba_q;    assign busWdata = wd_q;
  assign busRead  = rd_q;   assign busWrite = we_q;   assign busByte = byte_q;
  assign busStart = st_q;   assign portOut = pdr_q;   assign portDir = pcr_q;
  assign cpuState = cs_q;   assign cpuMode = sm_q;

  ///////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_rmwRead;
    busStart && !wr_q && job_q == J_RMW;
  endsequence
  sequence s_sameWrite(logic [23:0] a);
    busStart && wr_q && busAddr == a;
  endsequence
  a_mem_two_state: assert property (@(posedge clock) disable iff (!rstInt_n)
    busStart && region(busAddr) == R_MEM |=> !busStart ##1 eng_q != E_BUS
      || busStart) else $error("memory cycle not two states");
  a_p8_three_state: assert property (@(posedge clock) disable iff (!rstInt_n)
    busStart && region(busAddr) == R_P8 |=> !busStart [*2])
    else $error("8-bit peripheral cycle too short");
  a_p16_word_only: assert property (@(posedge clock) disable iff (!rstInt_n)
    (busRead || busWrite) && region(busAddr) == R_P16 |-> !busByte)
    else $error("byte strobe on 16-bit peripheral");
  a_split_order: assert property (@(posedge clock) disable iff (!rstInt_n)
    busStart && job_q == J_RD && lo_q == 1'b0 && busByte && !busAddr[0]
      && !da_q[0] && region(busAddr) == R_P8 && $past(cmdWord)
      |-> ##3 busStart && busAddr[0]) else $error("split order");
  a_rmw_same_addr: assert property (@(posedge clock) disable iff (!rstInt_n)
    s_rmwRead |-> (##2 s_sameWrite($past(busAddr,2)))
      or (##3 s_sameWrite($past(busAddr,3))))
    else $error("rmw address");
  a_unmapped_drop: assert property (@(posedge clock) disable iff (!rstInt_n)
    busWrite |-> region(busAddr) != R_NONE) else $error("unmapped write");
  a_abs8_upper: assert property (@(posedge clock) disable iff (!rstInt_n)
    cmdValid && rdy_q && cmdMode == M_ABS8 && cmdOp == OP_READ
      |=> busStart && busAddr[23:8] == 16'hFFFF)
    else $error("abs8 expansion");
  a_ind_target: assert property (@(posedge clock) disable iff (!rstInt_n)
    doneValid && job_q == J_IND |-> doneAddr[23:16] == 8'h00)
    else $error("indirect target width");
  a_exec_only: assert property (@(posedge clock) disable iff (!rstInt_n)
    busStart |-> cpuState == CS_EXEC) else $error("cycle outside exec");
endmodule

// ==== bench/cbrmw_mem_model.sv ====
// behavioural on-chip memory and peripheral store on the far side of the bus
`timescale 1ns/1ns
module cbrmw_mem_model (
  input  wire logic        clock,    // system clock
  input  wire logic [23:0] busAddr,  // cycle address
  input  wire logic [15:0] busWdata, // write data, bytes on both lanes
  input  wire logic        busRead,  // read level
  input  wire logic        busWrite, // write level
  input  wire logic        busByte,  // byte-sized cycle
  input  wire logic        busStart, // first state of a cycle
  output logic      [15:0] busRdata  // read data
);
  logic [7:0]  mem [bit [23:0]];
  logic [15:0] lastQ;
  logic [23:0] evenA;
  logic [23:0] oddA;

  assign evenA = {busAddr[23:1], 1'b0};
  assign oddA  = {busAddr[23:1], 1'b1};

  function automatic logic [7:0] rd(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction

  // even byte on the high lane; a released bus shows the inverse of the last
  always @* begin
    if (busRead) busRdata = {rd(evenA), rd(oddA)};
    else busRdata = ~lastQ;
  end

  // store whole words or the addressed byte lane
  always @(posedge clock) begin
    if (busRead) lastQ <= busRdata;
    if (busStart && busWrite) begin
      if (!busByte || !busAddr[0]) mem[evenA] = busWdata[15:8];
      if (!busByte || busAddr[0]) mem[oddA] = busWdata[7:0];
    end
  end
endmodule

// ==== bench/test_cpu_bus_access_and_bit_rmw.sv ====
// self-checking bench for the bus access unit
`timescale 1ns/1ns
`include "cbrmw_regs.svh"
module test_cpu_bus_access_and_bit_rmw;
  import cbrmw_pkg::*;
  logic         clock = 0, rst_n = 0, cmdValid = 0, cmdWord = 0;
  logic         cmdBitIn = 0, cmdCountWide = 0, haltReq = 0, wakeReq = 0;
  logic         excReq = 0, excDone = 0, cmdReady, doneValid, busRead;
  logic         busWrite, busByte, busStart;
  logic [23:0]  cmdField = 0, cmdPc = 0, cmdSrc = 0, cmdDst = 0;
  logic [23:0]  doneAddr, busAddr;
  logic [15:0]  cmdWdata = 0, cmdCount = 0, busRdata, doneData, busWdata;
  logic [7:0]   portPinIn = 0, portOut, portDir;
  logic [2:0]   cmdBitNum = 0;
  cbrmw_op_t    cmdOp = OP_READ;
  cbrmw_mode_t  cmdMode = M_ABS24;
  cbrmw_bitop_t cmdBitOp = B_SET;
  cbrmw_sub_t   haltMode = SM_SLEEP_HIGH, runMode = SM_ACT_HIGH, cpuMode;
  cbrmw_cpu_t   cpuState;
  int           err_count = 0, checked = 0, nStart, nWr, lat;
  logic [23:0]  addrQ [$];

  cbrmw_access_unit u_cbrmw_access_unit (.clock, .rst_n, .cmdValid, .cmdOp,
    .cmdMode, .cmdField, .cmdPc, .cmdWord, .cmdWdata, .cmdBitOp, .cmdBitNum,
    .cmdBitIn, .cmdSrc, .cmdDst, .cmdCount, .cmdCountWide, .haltReq,
    .haltMode, .wakeReq, .runMode, .excReq, .excDone, .busRdata, .portPinIn,
    .cmdReady, .doneValid, .doneData, .doneAddr, .busAddr, .busWdata,
    .busRead, .busWrite, .busByte, .busStart, .portOut, .portDir, .cpuState,
    .cpuMode);
  cbrmw_mem_model u_cbrmw_mem_model (.clock, .busAddr, .busWdata, .busRead,
    .busWrite, .busByte, .busStart, .busRdata);

  always #10 clock = ~clock;

  // record every bus cycle start and its address
  always @(posedge clock) begin
    if (busStart) begin
      addrQ.push_back(busAddr);
      nStart++;
      if (busWrite) nWr++;
    end
  end

  task automatic chk(string nm, logic [23:0] got, logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // offer one command, wait for the take, then for the result pulse
  task automatic run(cbrmw_op_t op, cbrmw_mode_t md, logic [23:0] f,
                     logic w, logic [15:0] wd);
    @(negedge clock);
    cmdOp = op;
    cmdMode = md;
    cmdField = f;
    cmdWord = w;
    cmdWdata = wd;
    addrQ = {};
    nStart = 0;
    nWr = 0;
    cmdValid = 1;
    do @(posedge clock); while (cmdReady !== 1'b1);
    @(negedge clock);
    cmdValid = 0;
    lat = 0;
    do begin
      @(negedge clock);
      lat++;
    end while (doneValid !== 1'b1 && lat < 40);
    chk("done", doneValid, 1);
  endtask

  task automatic t_reset();
    repeat (16) @(negedge clock);
    rst_n = 1;
    repeat (5) @(negedge clock);
    chk("reset", cpuState, CS_EXCEPT);
    chk("dirRst", portDir, `CBRMW_PCR_RESET);
    excDone = 1;
    @(negedge clock);
    excDone = 0;
    repeat (3) @(negedge clock);
    chk("exec", cpuState, CS_EXEC);
    $display("reset test done");
  endtask

  task automatic t_mem();
    run(OP_WRITE, M_ABS24, 24'hFF_F000, 1, 16'h1234);
    chk("ramLat", lat, 3);
    run(OP_READ, M_ABS16, 24'h00_F000, 1, 0);
    chk("abs16", addrQ[0], 24'hFF_F000);
    chk("ramRd", doneData, 16'h1234);
    run(OP_WRITE, M_ABS8, 24'h00_0080, 1, 16'h5678);
    chk("abs8", addrQ[0], 24'hFF_FF80);
    chk("p16Lat", lat, 3);
    run(OP_WRITE, M_ABS8, 24'h00_0080, 0, 16'h1111);
    chk("p16Byte", nWr, 0);
    run(OP_READ, M_ABS8, 24'h00_0080, 1, 0);
    chk("p16Rd", doneData, 16'h5678);
    run(OP_WRITE, M_ABS24, 24'h10_0000, 1, 16'h2222);
    chk("voidWr", nWr, 0);
    run(OP_READ, M_ABS24, 24'h10_0000, 1, 0);
    chk("voidRd", doneData, `CBRMW_UNDEF_READ);
    run(OP_WRITE, M_ABS24, 24'hFF_FFA0, 1, 16'hABCD);
    chk("p8Lat", lat, 7);
    chk("p8Cyc", nStart, 2);
    chk("p8Hi", addrQ[0], 24'hFF_FFA0);
    chk("p8Lo", addrQ[1], 24'hFF_FFA1);
    run(OP_READ, M_ABS24, 24'hFF_FFA0, 1, 0);
    chk("p8Rd", doneData, 16'hABCD);
    $display("memory test done");
  endtask

  task automatic t_branch();
    cmdPc = 24'h00_1000;
    run(OP_READ, M_IMM, 24'h00_5A5A, 1, 0);
    chk("imm", doneData, 16'h5A5A);
    chk("immBus", nStart, 0);
    run(OP_BRANCH, M_PCREL8, 24'h00_00FE, 0, 0);
    chk("rel8", doneAddr, 24'h00_0FFE);
    cmdPc = 24'h01_0000;
    run(OP_BRANCH, M_PCREL16, 24'h00_8000, 0, 0);
    chk("rel16", doneAddr, 24'h00_8000);
    u_cbrmw_mem_model.mem[24'h00_0010] = 8'h12;
    u_cbrmw_mem_model.mem[24'h00_0011] = 8'h34;
    run(OP_BRANCH, M_MEMIND, 24'h00_0010, 1, 0);
    chk("indAddr", addrQ[0], 24'h00_0010);
    chk("ind", doneAddr, 24'h00_1234);
    $display("branch test done");
  endtask

  task automatic t_bit();
    logic [7:0] ex [5] = '{8'h81, 8'h01, 8'h03, 8'h13, 8'h12};
    logic [2:0] bn [5] = '{3'h0, 3'h7, 3'h1, 3'h4, 3'h0};
    u_cbrmw_mem_model.mem[24'hFF_F100] = 8'h80;
    cmdBitIn = 1;
    for (int i = 0; i < 5; i++) begin
      cmdBitOp = cbrmw_bitop_t'(i);
      cmdBitNum = bn[i];
      run(OP_BIT, M_ABS24, 24'hFF_F100, 0, 0);
      chk("bitData", doneData[7:0], ex[i]);
      chk("bitMem", u_cbrmw_mem_model.mem[24'hFF_F100], ex[i]);
      chk("bitBack", addrQ[1], 24'hFF_F100);
    end
    portPinIn = 8'h40;
    run(OP_WRITE, M_ABS8, 24'h00_00E8, 0, 16'h3F3F);
    run(OP_WRITE, M_ABS8, 24'h00_00D8, 0, 16'h8080);
    chk("dir", portDir, 8'h3F);
    cmdBitOp = B_SET;
    cmdBitNum = 0;
    run(OP_BIT, M_ABS8, 24'h00_00D8, 0, 0);
    chk("pdrRmw", portOut, 8'h41);
    run(OP_WRITE, M_ABS24, 24'hFF_F300, 0, 16'h8080);
    run(OP_BIT, M_ABS24, 24'hFF_F300, 0, 0);
    run(OP_WRITE, M_ABS8, 24'h00_00D8, 0, {2{doneData[7:0]}});
    chk("shadow", portOut, 8'h81);
    cmdBitOp = B_CLR;
    run(OP_BIT, M_ABS8, 24'h00_00E8, 0, 0);
    chk("pcrRmw", portDir, 8'hFE);
    $display("bit test done");
  endtask

  task automatic t_move_timer();
    logic [15:0] v;
    cmdSrc = 24'hFF_F000;
    cmdDst = 24'hFF_F200;
    cmdCount = 16'h0102;
    run(OP_MOVE, M_ABS24, 0, 0, 0);
    chk("mv0", u_cbrmw_mem_model.mem[24'hFF_F200], 8'h12);
    chk("mv1", u_cbrmw_mem_model.mem[24'hFF_F201], 8'h34);
    chk("mvEnd", u_cbrmw_mem_model.mem.exists(24'hFF_F202), 0);
    run(OP_WRITE, M_ABS24, `CBRMW_TMR_ADDR, 0, 16'h4040);
    run(OP_READ, M_ABS24, `CBRMW_TMR_ADDR, 0, 0);
    v = doneData;
    run(OP_READ, M_ABS24, `CBRMW_TMR_ADDR, 0, 0);
    chk("tmrRun", v === doneData, 0);
    $display("move and timer test done");
  endtask

  task automatic t_states();
    runMode = SM_SUBACT;
    repeat (2) @(negedge clock);
    chk("sub", cpuMode, SM_SUBACT);
    runMode = SM_ACT_HIGH;
    haltMode = SM_WATCH;
    haltReq = 1;
    repeat (3) @(negedge clock);
    chk("halt", cpuState, CS_HALT);
    chk("watch", cpuMode, SM_WATCH);
    haltReq = 0;
    wakeReq = 1;
    repeat (3) @(negedge clock);
    chk("wake", cpuState, CS_EXCEPT);
    wakeReq = 0;
    excDone = 1;
    @(negedge clock);
    excDone = 0;
    repeat (3) @(negedge clock);
    chk("back", cpuState, CS_EXEC);
    $display("state test done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    t_reset();
    t_mem();
    t_branch();
    t_bit();
    t_move_timer();
    t_states();
    wrap_up();
  end

  // watchdog well beyond the expected run length
  initial begin
    #200_000;
    err_count++;
    wrap_up();
  end
endmodule
